// ---- hdl/oss_chk_if.sv ----
`timescale 1ns/1ps
interface oss_chk_if
  import oss_pkg::*;
  ();
  logic os_en;
  logic task_sw;
  logic align_mask;
  logic ac_flag;
  logic [1:0] current_privilege_level;
  logic [5:0] addr_low;
  oss_fault_t fault;

  modport chk (
    input os_en,
    input task_sw,
    input align_mask,
    input ac_flag,
    input current_privilege_level,
    input addr_low,
    output fault
  );

  modport ctl (
    output os_en,
    output task_sw,
    output align_mask,
    output ac_flag,
    output current_privilege_level,
    output addr_low,
    input fault
  );
endinterface : oss_chk_if

// ---- hdl/oss_defines.svh ----
`ifndef OSS_DEFINES_SVH
`define OSS_DEFINES_SVH

// register byte offsets on the apb bus
`define OSS_CTRL 8'h00
`define OSS_FEAT_LO 8'h04
`define OSS_FEAT_HI 8'h08
`define OSS_MASK_LO 8'h0c
`define OSS_MASK_HI 8'h10
`define OSS_ADDR 8'h14
`define OSS_CMD 8'h18
`define OSS_MOD_LO 8'h1c
`define OSS_MOD_HI 8'h20
`define OSS_INIT_LO 8'h24
`define OSS_INIT_HI 8'h28
`define OSS_FPW 8'h2c
`define OSS_FPTAG 8'h30
`define OSS_STATUS 8'h34
`define OSS_HDR_LO 8'h38
`define OSS_HDR_HI 8'h3c
`define OSS_SAVED_LO 8'h40
`define OSS_SAVED_HI 8'h44

// control register field positions
`define OSS_B_OSEN 0
`define OSS_B_TS 3
`define OSS_B_AM 4
`define OSS_B_ACF 5
`define OSS_B_GUEST 6
`define OSS_B_FPNZ 7
`define OSS_B_CPL 8
`define OSS_CTRL_W 10

// command bits
`define OSS_B_SAVE 0
`define OSS_B_RESTORE 1

// reset values
`define OSS_CTRL_RST 10'h000
`define OSS_FPW_RST 32'h0000_037f
`define OSS_FPTAG_RST 16'hffff

// x87 initial configuration
`define OSS_FP_CW_INIT 16'h037f
`define OSS_FP_SW_INIT 16'h0000
`define OSS_FP_TAG_INIT 16'hffff

// save area layout and checks
`define OSS_ALIGN_BITS 6
`define OSS_CPL_USER 2'h3
`define OSS_HDR_OFF 32'h0000_0200
`define OSS_SIMD_OFF 32'h0000_0018
`define OSS_COMP_BASE 32'h0000_0240
`define OSS_COMP_STRIDE 32'h0000_0040

`endif

// ---- hdl/oss_fault_chk.sv ----
`timescale 1ns/1ps
`include "oss_defines.svh"
module oss_fault_chk
  import oss_pkg::*;
  (
  oss_chk_if.chk c
);

  // fault checks in fixed priority order
  always_comb begin
    if (!c.os_en) begin
      c.fault = OSS_F_UD;
    end else if (c.task_sw) begin
      c.fault = OSS_F_NM;
    end else if (c.addr_low != 6'h00) begin
      if (c.align_mask && (c.current_privilege_level == `OSS_CPL_USER) && c.ac_flag) begin
        c.fault = OSS_F_AC;
      end else begin
        c.fault = OSS_F_GP;
      end
    end else begin
      c.fault = OSS_F_NONE;
    end
  end

endmodule : oss_fault_chk

// ---- hdl/oss_pkg.sv ----
package oss_pkg;

  typedef enum logic [2:0] {
    OSS_IDLE = 3'b000,
    OSS_RD_HDR = 3'b001,
    OSS_WR_HDR = 3'b010,
    OSS_WR_SIMD = 3'b011,
    OSS_NEXT = 3'b100,
    OSS_WR_COMP = 3'b101
  } oss_state_t;

  typedef enum logic [2:0] {
    OSS_F_NONE = 3'b000,
    OSS_F_UD = 3'b001,
    OSS_F_NM = 3'b010,
    OSS_F_GP = 3'b011,
    OSS_F_AC = 3'b100
  } oss_fault_t;

  typedef enum logic [1:0] {
    OSS_K_HDR = 2'b00,
    OSS_K_SIMD = 2'b01,
    OSS_K_COMP = 2'b10
  } oss_kind_t;

endpackage : oss_pkg

// ---- hdl/oss_save_unit.sv ----
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "oss_defines.svh"
module oss_save_unit
  import oss_pkg::*;
#(
  parameter int AW = 32
) (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic MEM_REQ,
  output logic MEM_WE,
  output logic [AW-1:0] MEM_ADDR,
  output logic [1:0] MEM_KIND,
  output logic [5:0] MEM_COMP,
  output logic [63:0] MEM_WDATA,
  input wire logic [63:0] MEM_RDATA,
  input wire logic MEM_ACK,
  output logic BUSY,
  output logic [2:0] FAULT_CODE
);

  // configuration and state registers
  logic [`OSS_CTRL_W-1:0] ctrl_reg;
  logic [63:0] feat_reg;
  logic [63:0] mask_reg;
  logic [AW-1:0] addr_reg;
  logic [63:0] init_reg;
  logic [31:0] fpw_reg;
  logic [15:0] ftag_reg;
  logic [63:0] mod_reg;
  logic rec_valid_reg;
  logic [1:0] rec_cpl_reg;
  logic rec_guest_reg;
  logic [AW-1:0] rec_addr_reg;
  oss_state_t state_reg;
  oss_fault_t fault_reg;
  logic modopt_reg;
  logic done_reg;
  logic simd_reg;
  logic simd_done_reg;
  logic [63:0] rfbm_reg;
  logic [63:0] hdr_reg;
  logic [63:0] pend_reg;
  logic [63:0] saved_reg;
  logic mem_we_reg;
  logic [AW-1:0] mem_addr_reg;
  oss_kind_t mem_kind_reg;
  logic [5:0] mem_comp_reg;
  logic [63:0] mem_wdata_reg;
  logic [31:0] prdata_reg;

  logic wr_acc;
  logic setup;
  logic hit;
  logic [31:0] rd_mux;
  logic [63:0] rfbm;
  logic x87_init;
  logic [63:0] comp_init;
  logic modopt;
  logic [63:0] hdr_next;
  logic start_save;
  logic do_restore;
  logic scan_found;
  logic [5:0] scan_idx;
  logic [1:0] current_privilege_level;
  logic guest;
  oss_chk_if chk_bus ();
  oss_fault_chk u_chk (
    .c (chk_bus.chk)
  );
  oss_scan #(
    .N (64),
    .IW (6)
  ) u_scan (
    .pend (pend_reg),
    .found (scan_found),
    .idx (scan_idx)
  );
  // apb strobes
  assign wr_acc = PSEL && PENABLE && PWRITE;
  assign setup = PSEL && !PENABLE;
  assign current_privilege_level = ctrl_reg[`OSS_B_CPL +: 2];
  assign guest = ctrl_reg[`OSS_B_GUEST];
  assign start_save = wr_acc && (PADDR == `OSS_CMD) && PWDATA[`OSS_B_SAVE]
                      && (state_reg == OSS_IDLE);
  assign do_restore = wr_acc && (PADDR == `OSS_CMD) && PWDATA[`OSS_B_RESTORE]
                      && (state_reg == OSS_IDLE);

  // fault checker inputs
  assign chk_bus.os_en = ctrl_reg[`OSS_B_OSEN];
  assign chk_bus.task_sw = ctrl_reg[`OSS_B_TS];
  assign chk_bus.align_mask = ctrl_reg[`OSS_B_AM];
  assign chk_bus.ac_flag = ctrl_reg[`OSS_B_ACF];
  assign chk_bus.current_privilege_level = current_privilege_level;
  assign chk_bus.addr_low = addr_reg[`OSS_ALIGN_BITS-1:0];

  // requested bitmap and component status
  assign rfbm = feat_reg & mask_reg;
  assign x87_init = (fpw_reg[15:0] == `OSS_FP_CW_INIT)
                    && (fpw_reg[31:16] == `OSS_FP_SW_INIT)
                    && (ftag_reg == `OSS_FP_TAG_INIT)
                    && !ctrl_reg[`OSS_B_FPNZ];
  assign comp_init = {init_reg[63:1], x87_init};
  assign modopt = rec_valid_reg && (rec_cpl_reg == current_privilege_level)
                  && (rec_guest_reg == guest) && (rec_addr_reg == addr_reg);
  // unrequested bits from memory, requested ones from init status
  assign hdr_next = (MEM_RDATA & ~rfbm_reg) | (rfbm_reg & ~comp_init);
  // software-written configuration
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_reg <= `OSS_CTRL_RST;
      feat_reg <= 64'h0;
      mask_reg <= 64'h0;
      addr_reg <= '0;
      init_reg <= 64'h0;
      fpw_reg <= `OSS_FPW_RST;
      ftag_reg <= `OSS_FPTAG_RST;
    end else if (wr_acc) begin
      unique case (PADDR)
        `OSS_CTRL: ctrl_reg <= PWDATA[`OSS_CTRL_W-1:0];
        `OSS_FEAT_LO: feat_reg[31:0] <= PWDATA;
        `OSS_FEAT_HI: feat_reg[63:32] <= PWDATA;
        `OSS_MASK_LO: mask_reg[31:0] <= PWDATA;
        `OSS_MASK_HI: mask_reg[63:32] <= PWDATA;
        `OSS_ADDR: addr_reg <= AW'(PWDATA);
        `OSS_INIT_LO: init_reg[31:0] <= PWDATA;
        `OSS_INIT_HI: init_reg[63:32] <= PWDATA;
        `OSS_FPW: fpw_reg <= PWDATA;
        `OSS_FPTAG: ftag_reg <= PWDATA[15:0];
        default: ;
      endcase
    end
  end
  // modified tracking, write-one-to-set, restore clears requested bits
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      mod_reg <= {64{1'b1}};
    end else if (do_restore) begin
      mod_reg <= ~rfbm;
    end else if (wr_acc && (PADDR == `OSS_MOD_LO)) begin
      mod_reg[31:0] <= mod_reg[31:0] | PWDATA;
    end else if (wr_acc && (PADDR == `OSS_MOD_HI)) begin
      mod_reg[63:32] <= mod_reg[63:32] | PWDATA;
    end
  end
  // last restore record
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rec_valid_reg <= 1'b0;
      rec_cpl_reg <= 2'h0;
      rec_guest_reg <= 1'b0;
      rec_addr_reg <= '0;
    end else if (do_restore) begin
      rec_valid_reg <= 1'b1;
      rec_cpl_reg <= current_privilege_level;
      rec_guest_reg <= guest;
      rec_addr_reg <= addr_reg;
    end
  end
  // save sequencer and memory request registers
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg <= OSS_IDLE;
      fault_reg <= OSS_F_NONE;
      modopt_reg <= 1'b0;
      done_reg <= 1'b0;
      simd_reg <= 1'b0;
      simd_done_reg <= 1'b0;
      rfbm_reg <= 64'h0;
      hdr_reg <= 64'h0;
      pend_reg <= 64'h0;
      saved_reg <= 64'h0;
      mem_we_reg <= 1'b0;
      mem_addr_reg <= '0;
      mem_kind_reg <= OSS_K_HDR;
      mem_comp_reg <= 6'h00;
      mem_wdata_reg <= 64'h0;
    end else begin
      unique case (state_reg)
        OSS_IDLE: begin
          if (start_save) begin
            // checks decided before any memory access
            fault_reg <= chk_bus.fault;
            done_reg <= 1'b0;
            saved_reg <= 64'h0;
            simd_done_reg <= 1'b0;
            if (chk_bus.fault == OSS_F_NONE) begin
              rfbm_reg <= rfbm;
              modopt_reg <= modopt;
              mem_we_reg <= 1'b0;
              mem_kind_reg <= OSS_K_HDR;
              mem_addr_reg <= addr_reg + AW'(`OSS_HDR_OFF);
              state_reg <= OSS_RD_HDR;
            end else begin
              done_reg <= 1'b1;
            end
          end
        end
        OSS_RD_HDR: begin
          if (MEM_ACK) begin
            hdr_reg <= hdr_next;
            mem_wdata_reg <= hdr_next;
            mem_we_reg <= 1'b1;
            // requested, still-present components; when modopt_reg is set, only the modified ones
            pend_reg <= rfbm_reg & hdr_next
                        & ~(modopt_reg ? ~mod_reg : 64'h0);
            simd_reg <= rfbm_reg[1] || rfbm_reg[2];
            state_reg <= OSS_WR_HDR;
          end
        end
        OSS_WR_HDR: begin
          if (MEM_ACK) begin
            if (simd_reg) begin
              mem_kind_reg <= OSS_K_SIMD;
              mem_addr_reg <= addr_reg + AW'(`OSS_SIMD_OFF);
              state_reg <= OSS_WR_SIMD;
            end else begin
              state_reg <= OSS_NEXT;
            end
          end
        end
        OSS_WR_SIMD: begin
          if (MEM_ACK) begin
            simd_done_reg <= 1'b1;
            state_reg <= OSS_NEXT;
          end
        end
        OSS_NEXT: begin
          if (scan_found) begin
            mem_kind_reg <= OSS_K_COMP;
            mem_comp_reg <= scan_idx;
            mem_addr_reg <= addr_reg + AW'(`OSS_COMP_BASE)
                            + AW'(scan_idx) * AW'(`OSS_COMP_STRIDE);
            state_reg <= OSS_WR_COMP;
          end else begin
            mem_we_reg <= 1'b0;
            done_reg <= 1'b1;
            state_reg <= OSS_IDLE;
          end
        end
        OSS_WR_COMP: begin
          if (MEM_ACK) begin
            pend_reg[mem_comp_reg] <= 1'b0;
            saved_reg[mem_comp_reg] <= 1'b1;
            state_reg <= OSS_NEXT;
          end
        end
        default: begin
          state_reg <= OSS_IDLE;
        end
      endcase
    end
  end

  // read mux, decoded during the setup phase
  always_comb begin
    hit = 1'b1;
    rd_mux = 32'h0;
    unique case (PADDR)
      `OSS_CTRL: rd_mux = 32'(ctrl_reg);
      `OSS_FEAT_LO: rd_mux = feat_reg[31:0];
      `OSS_FEAT_HI: rd_mux = feat_reg[63:32];
      `OSS_MASK_LO: rd_mux = mask_reg[31:0];
      `OSS_MASK_HI: rd_mux = mask_reg[63:32];
      `OSS_ADDR: rd_mux = 32'(addr_reg);
      `OSS_CMD: rd_mux = 32'h0;
      `OSS_MOD_LO: rd_mux = mod_reg[31:0];
      `OSS_MOD_HI: rd_mux = mod_reg[63:32];
      `OSS_INIT_LO: rd_mux = init_reg[31:0];
      `OSS_INIT_HI: rd_mux = init_reg[63:32];
      `OSS_FPW: rd_mux = fpw_reg;
      `OSS_FPTAG: rd_mux = {16'h0, ftag_reg};
      `OSS_STATUS: rd_mux = {25'h0, simd_done_reg, done_reg, modopt_reg,
                             fault_reg, state_reg != OSS_IDLE};
      `OSS_HDR_LO: rd_mux = hdr_reg[31:0];
      `OSS_HDR_HI: rd_mux = hdr_reg[63:32];
      `OSS_SAVED_LO: rd_mux = saved_reg[31:0];
      `OSS_SAVED_HI: rd_mux = saved_reg[63:32];
      default: hit = 1'b0;
    endcase
  end

  // read data registered ahead of the access phase
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      prdata_reg <= 32'h0;
    end else if (setup) begin
      prdata_reg <= rd_mux;
    end
  end

  // outputs
  assign PRDATA = prdata_reg;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !hit;
  assign MEM_REQ = (state_reg == OSS_RD_HDR) || (state_reg == OSS_WR_HDR)
                   || (state_reg == OSS_WR_SIMD) || (state_reg == OSS_WR_COMP);
  assign MEM_WE = mem_we_reg;
  assign MEM_ADDR = mem_addr_reg;
  assign MEM_KIND = mem_kind_reg;
  assign MEM_COMP = mem_comp_reg;
  assign MEM_WDATA = mem_wdata_reg;
  assign BUSY = state_reg != OSS_IDLE;
  assign FAULT_CODE = fault_reg;

endmodule : oss_save_unit

// ---- hdl/oss_scan.sv ----
`timescale 1ns/1ps
module oss_scan #(
  parameter int N = 64,
  parameter int IW = 6
) (
  input wire logic [N-1:0] pend,
  output logic found,
  output logic [IW-1:0] idx
);

  logic [N:0] below;
  logic [IW-1:0] acc [0:N];

  assign below[0] = 1'b0;
  assign acc[0] = '0;

  // lowest set bit wins; chain carries "seen one already"
  for (genvar i = 0; i < N; i++) begin : g_bit
    assign below[i+1] = below[i] | pend[i];
    assign acc[i+1] = (pend[i] && !below[i]) ? IW'(i) : acc[i];
  end

  assign found = below[N];
  assign idx = acc[N];

endmodule : oss_scan

// ---- tb/oss_mem_model.sv ----
`timescale 1ns/1ps
module oss_mem_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req,
  input wire logic we,
  input wire logic [1:0] kind,
  input wire logic [63:0] wdata,
  input wire logic [3:0] lat,
  input wire logic load,
  input wire logic [63:0] load_val,
  output logic [63:0] rdata,
  output logic ack,
  output logic [63:0] hdr
);
  logic [3:0] wait_q;
  // header word of the save area
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) hdr <= 64'h0;
    else if (load) hdr <= load_val;
    else if (req && ack && we && kind == 2'h0) hdr <= wdata;
  end
  // one-cycle answer after lat waiting cycles
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
      wait_q <= 4'h0;
    end else begin
      ack <= req && !ack && wait_q >= lat;
      wait_q <= (req && !ack && wait_q < lat) ? wait_q + 4'h1 : 4'h0;
    end
  end
  // data valid only while answering
  assign rdata = ack ? hdr : ~hdr;
endmodule : oss_mem_model

// ---- tb/oss_properties.sv ----
`timescale 1ns/1ps
module oss_props
  import oss_pkg::*;
#(
  parameter int AW = 32
) (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic MEM_REQ,
  input wire logic MEM_WE,
  input wire logic [AW-1:0] MEM_ADDR,
  input wire logic [1:0] MEM_KIND,
  input wire logic [5:0] MEM_COMP,
  input wire logic [63:0] MEM_WDATA,
  input wire logic [63:0] MEM_RDATA,
  input wire logic MEM_ACK,
  input wire logic BUSY,
  input wire logic [2:0] FAULT_CODE
);
  logic [31:0] ctl, adr;
  logic [63:0] feat, msk, rq, hrd, hwr;
  logic wr, sv, hw;
  logic [2:0] fx;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  // save command and the fault it should raise
  assign wr = PSEL && PENABLE && PWRITE;
  assign sv = wr && PADDR == 8'h18 && PWDATA[0] && !BUSY;
  assign hw = MEM_REQ && MEM_WE && MEM_KIND == 2'h0;
  assign rq = feat & msk;
  assign fx = !ctl[0] ? 3'h1 : ctl[3] ? 3'h2 : adr[5:0] == 6'h00 ? 3'h0 :
    (ctl[4] && ctl[5] && ctl[9:8] == 2'h3) ? 3'h4 : 3'h3;
  // shadow of the programmed registers
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctl <= 32'h0;
      adr <= 32'h0;
      feat <= 64'h0;
      msk <= 64'h0;
    end else if (wr) begin
      case (PADDR)
        8'h00: ctl <= PWDATA;
        8'h04: feat[31:0] <= PWDATA;
        8'h08: feat[63:32] <= PWDATA;
        8'h0c: msk[31:0] <= PWDATA;
        8'h10: msk[63:32] <= PWDATA;
        8'h14: adr <= PWDATA;
        default: ;
      endcase
    end
  end
  // header as read and as written back
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      hrd <= 64'h0;
      hwr <= 64'h0;
    end else if (MEM_REQ && MEM_ACK && MEM_KIND == 2'h0) begin
      if (MEM_WE) hwr <= MEM_WDATA;
      else hrd <= MEM_RDATA;
    end
  end
  a_ud_fault: assert property (sv && fx == 3'h1 |=> FAULT_CODE == 3'h1 && !BUSY)
    else $error("invalid opcode fault missing");
  a_nm_fault: assert property (sv && fx == 3'h2 |=> FAULT_CODE == 3'h2 && !BUSY)
    else $error("device unavailable fault missing");
  a_gp_fault: assert property (sv && fx == 3'h3 |=> FAULT_CODE == 3'h3)
    else $error("protection fault missing");
  a_ac_fault: assert property (sv && fx == 3'h4 |=> FAULT_CODE == 3'h4)
    else $error("alignment check fault missing");
  a_fault_quiet: assert property (sv && fx != 3'h0 |=> !MEM_REQ [*3])
    else $error("memory touched on fault");
  a_header_first: assert property (sv && fx == 3'h0 |=>
    MEM_REQ && !MEM_WE && MEM_KIND == 2'h0 && MEM_ADDR == AW'(adr + 32'h200))
    else $error("header not read first");
  a_req_held: assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR)
    && $stable(MEM_KIND) && $stable(MEM_WDATA)) else $error("request dropped early");
  a_header_keep: assert property (hw |-> ((MEM_WDATA ^ hrd) & ~rq) == 64'h0)
    else $error("unrequested header bit changed");
  a_comp_listed: assert property (MEM_REQ && MEM_KIND == 2'h2 |->
    hwr[MEM_COMP] && rq[MEM_COMP]) else $error("component written outside header");
  a_simd_slot: assert property (MEM_REQ && MEM_KIND == 2'h1 |->
    MEM_WE && (rq[1] || rq[2]) && MEM_ADDR == AW'(adr + 32'h18))
    else $error("simd slot write wrong");
endmodule : oss_props
bind oss_save_unit oss_props #(.AW(AW)) oss_props_i (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR), .MEM_KIND(MEM_KIND),
  .MEM_COMP(MEM_COMP), .MEM_WDATA(MEM_WDATA), .MEM_RDATA(MEM_RDATA),
  .MEM_ACK(MEM_ACK), .BUSY(BUSY), .FAULT_CODE(FAULT_CODE));

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, mem_req, mem_we, mem_ack;
  logic busy, load, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, mem_addr, base, rd;
  logic [1:0] mem_kind;
  logic [5:0] mem_comp;
  logic [63:0] mem_wdata, mem_rdata, hdr, load_val, comps;
  logic [2:0] fault_code;
  logic [3:0] lat;
  int n_mismatch, samples_checked, n_simd;
  oss_save_unit oss_save_unit_i (.SYS_CLK(clk), .RST_N(rst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .MEM_REQ(mem_req), .MEM_WE(mem_we),
    .MEM_ADDR(mem_addr), .MEM_KIND(mem_kind), .MEM_COMP(mem_comp), .MEM_WDATA(mem_wdata),
    .MEM_RDATA(mem_rdata), .MEM_ACK(mem_ack), .BUSY(busy), .FAULT_CODE(fault_code));
  oss_mem_model oss_mem_model_i (.clk(clk), .rst_n(rst_n), .req(mem_req), .we(mem_we),
    .kind(mem_kind), .wdata(mem_wdata), .lat(lat), .load(load), .load_val(load_val),
    .rdata(mem_rdata), .ack(mem_ack), .hdr(hdr));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // record what reaches the save area
  always @(posedge clk) begin
    if (mem_req && mem_ack && mem_we && mem_kind == 2'h1) n_simd++;
    if (mem_req && mem_ack && mem_we && mem_kind == 2'h2) begin
      comps[mem_comp] = 1'b1;
      chk("comp addr", {32'h0, base + 32'h240 + {26'h0, mem_comp} * 32'h40}, {32'h0, mem_addr});
    end
  end
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input string s, input logic [63:0] e, input logic [63:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    if (n >= 20) begin
      n_mismatch++;
      end_of_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rchk(input string s, input logic [7:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    chk(s, {32'h0, e}, {32'h0, rd});
  endtask : rchk
  task automatic wadr(input logic [31:0] a);
    base = a;
    apb(8'h14, 1'b1, a);
  endtask : wadr
  task automatic run(input logic [31:0] cmd);
    int n;
    comps = 64'h0;
    n_simd = 0;
    apb(8'h18, 1'b1, cmd);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (busy !== 1'b0 && n < 200);
    if (n >= 200) begin
      n_mismatch++;
      end_of_test();
    end
  endtask : run
  task automatic s_reset;
    rchk("ctrl", 8'h00, 32'h0);
    rchk("fp words", 8'h2c, 32'h037f);
    rchk("fp tag", 8'h30, 32'hffff);
    rchk("mod", 8'h1c, 32'hffff_ffff);
    rchk("unmapped", 8'h48, 32'h0);
    chk("slave error", 64'h1, {63'h0, err});
  endtask : s_reset
  task automatic s_faults;
    logic [31:0] c [5] = '{32'h0, 32'h9, 32'h1, 32'h331, 32'h311};
    logic [31:0] a [5] = '{32'h1000, 32'h1000, 32'h1004, 32'h1008, 32'h1010};
    logic [31:0] f [5] = '{32'h1, 32'h2, 32'h3, 32'h4, 32'h3};
    for (int i = 0; i < 5; i++) begin
      apb(8'h00, 1'b1, c[i]);
      wadr(a[i]);
      run(32'h1);
      rchk("fault status", 8'h34, 32'h20 | (f[i] << 1));
      chk("fault writes", 64'h0, comps | 64'(n_simd));
      chk("fault code", 64'(f[i]), {61'h0, fault_code});
    end
  endtask : s_faults
  task automatic s_init;
    apb(8'h04, 1'b1, 32'h7);
    apb(8'h0c, 1'b1, 32'h5);
    apb(8'h10, 1'b1, 32'h1);
    apb(8'h00, 1'b1, 32'h1);
    apb(8'h24, 1'b1, 32'hffff_fffb);
    wadr(32'h1000);
    load_val <= 64'hf2;
    load <= 1'b1;
    lat <= 4'h3;
    @(posedge clk);
    load <= 1'b0;
    run(32'h1);
    chk("header", 64'hf6, hdr);
    chk("components", 64'h4, comps);
    chk("simd slot", 64'h1, 64'(n_simd));
    rchk("saved", 8'h40, 32'h4);
    rchk("header reg", 8'h38, 32'hf6);
  endtask : s_init
  task automatic s_x87;
    logic [31:0] w [4] = '{32'h037e, 32'h1_037f, 32'h037f, 32'h037f};
    logic [31:0] t [4] = '{32'hffff, 32'hffff, 32'hfffe, 32'hffff};
    logic [31:0] c [4] = '{32'h1, 32'h1, 32'h1, 32'h81};
    lat <= 4'h0;
    for (int i = 0; i < 4; i++) begin
      apb(8'h2c, 1'b1, w[i]);
      apb(8'h30, 1'b1, t[i]);
      apb(8'h00, 1'b1, c[i]);
      run(32'h1);
      chk("x87 header", 64'h1, {63'h0, hdr[0]});
      chk("x87 written", 64'h5, comps);
    end
  endtask : s_x87
  task automatic s_mod;
    logic [31:0] c [3] = '{32'h81, 32'hc1, 32'h181};
    logic [31:0] a [3] = '{32'h1040, 32'h1000, 32'h1000};
    run(32'h2);
    rchk("mod lo", 8'h1c, 32'hffff_fffa);
    rchk("mod hi", 8'h20, 32'hffff_ffff);
    apb(8'h1c, 1'b1, 32'h1);
    rchk("mod set", 8'h1c, 32'hffff_fffb);
    run(32'h1);
    chk("opt components", 64'h1, comps);
    chk("opt simd slot", 64'h1, 64'(n_simd));
    rchk("opt status", 8'h34, 32'h70);
    for (int i = 0; i < 3; i++) begin
      apb(8'h00, 1'b1, 32'h81);
      wadr(32'h1000);
      run(32'h2);
      apb(8'h00, 1'b1, c[i]);
      wadr(a[i]);
      run(32'h1);
      chk("record mismatch", 64'h5, comps);
    end
    // save and restore in one command: restore clears the modified bit first
    apb(8'h00, 1'b1, 32'h81);
    apb(8'h1c, 1'b1, 32'h1);
    run(32'h3);
    chk("both components", 64'h0, comps);
    chk("both simd slot", 64'h1, 64'(n_simd));
  endtask : s_mod
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    load = 1'b0;
    load_val = 64'h0;
    lat = 4'h0;
    base = 32'h0;
    comps = 64'h0;
    n_simd = 0;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    s_reset();
    s_faults();
    s_init();
    s_x87();
    s_mod();
    end_of_test();
  end
endmodule : testbench
